// >>> vts_pkg.sv
// Constants for the voltage reference and temperature indicator control block.
// Assumes a 32-bit classic Wishbone slave port on a 40 MHz system clock.
package vts_pkg;

   // -------------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------------
   localparam logic [3:0] OFF_VREF_TEMP_CONTROL = 4'h0;
   localparam logic [3:0] OFF_CONV_CONTROL = 4'h4;
   localparam logic [3:0] OFF_RESULT_HIGH = 4'h8;
   localparam logic [3:0] OFF_RESULT_LOW = 4'hC;

   // -------------------------------------------------------------------
   // vref_temp_control field positions and reset value
   // -------------------------------------------------------------------
   localparam int POS_REFERENCE_ENABLE = 7;
   localparam int POS_REFERENCE_READY = 6;
   localparam int POS_TEMP_SENSOR_ENABLE = 5;
   localparam int POS_TEMP_RANGE_SELECT = 4;
   localparam int POS_COMP_GAIN_LO = 2;
   localparam int POS_CONV_GAIN_LO = 0;
   localparam logic [7:0] RST_VREF_TEMP_CONTROL = 8'h00;

   // -------------------------------------------------------------------
   // Converter control field positions and reset value
   // -------------------------------------------------------------------
   localparam int POS_CONV_GO = 0;
   localparam int POS_ACQ_SETTLED = 2;
   localparam int POS_CHANNEL_LO = 4;
   localparam logic [3:0] RST_CHANNEL = 4'h0;
   localparam logic [3:0] TEMP_CHANNEL = 4'h8;

   // -------------------------------------------------------------------
   // Reference gain codes, one-hot level outputs {4x, 2x, 1x}
   // -------------------------------------------------------------------
   localparam logic [1:0] GAIN_CODE_OFF = 2'h0;
   localparam logic [1:0] GAIN_CODE_1X = 2'h1;
   localparam logic [1:0] GAIN_CODE_2X = 2'h2;
   localparam logic [1:0] GAIN_CODE_4X = 2'h3;
   localparam logic [2:0] LEVEL_OFF = 3'h0;
   localparam logic [2:0] LEVEL_1X = 3'h1;
   localparam logic [2:0] LEVEL_2X = 3'h2;
   localparam logic [2:0] LEVEL_4X = 3'h4;

   // -------------------------------------------------------------------
   // Converter and timing
   // -------------------------------------------------------------------
   localparam int RESULT_WIDTH = 10;
   localparam int SETTLE_CYCLES = 3;
   localparam int CLOCK_MHZ = 40;
   localparam int ACQ_TIME_US = 200;
   localparam int ACQ_CYCLES = ACQ_TIME_US * CLOCK_MHZ;

endpackage

// >>> vts_sar_if.sv
// Carrier between the control top and the successive-approximation engine.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface vts_sar_if;
   logic start;
   logic busy;
   logic done;
   logic [9:0] result;
   logic [9:0] trial;

   modport ctrl (output start, input busy, input done, input result, input trial);
   modport engine (input start, output busy, output done, output result, output trial);
endinterface
`default_nettype wire

// >>> vts_sar_engine.sv
// Successive-approximation sequencer, one result bit per settle window.
// Assumes an external comparator that is high while input exceeds the trial code.
`timescale 1ns/10ps
`default_nettype none
module vts_sar_engine #(
   parameter int SETTLE = vts_pkg::SETTLE_CYCLES
) (
   input wire logic mclk, // System clock
   input wire logic rst, // Async reset, high
   input wire logic compRaw, // Comparator pin, asynchronous
   vts_sar_if.engine sar // Start, busy, done, result
);
   typedef enum logic [0:0] {IDLE, CONVERT} vts_sar_state_t;

   vts_sar_state_t state_r;
   logic compMeta_r;
   logic compSync_r;
   logic [3:0] bitIdx_r;
   logic [3:0] settle_r;
   logic [9:0] keptTrial;

   // Weight of one trial bit
   function automatic logic [9:0] bitMask(input logic [3:0] idx);
      bitMask = 10'h001 << idx;
   endfunction

   // -------------------------------------------------------------------
   // Comparator synchroniser
   // -------------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         compMeta_r <= 1'b0;
         compSync_r <= 1'b0;
      end else begin
         compMeta_r <= compRaw;
         compSync_r <= compMeta_r;
      end
   end

   // Bit under test kept only if the comparator says input is above it
   assign keptTrial = compSync_r ? sar.trial : (sar.trial & ~bitMask(bitIdx_r));

   // -------------------------------------------------------------------
   // Approximation sequence
   // -------------------------------------------------------------------
   // Settle window covers the two synchroniser stages plus analog settling
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r <= IDLE;
         sar.busy <= 1'b0;
         sar.done <= 1'b0;
         sar.result <= 10'h000;
         sar.trial <= 10'h000;
         bitIdx_r <= 4'h0;
         settle_r <= 4'h0;
      end else begin
         sar.done <= 1'b0;
         unique case (state_r)
            IDLE: begin
               if (sar.start) begin
                  state_r <= CONVERT;
                  sar.busy <= 1'b1;
                  sar.trial <= bitMask(4'd9);
                  bitIdx_r <= 4'd9;
                  settle_r <= 4'h0;
               end
            end
            CONVERT: begin
               // One extra cycle covers the top's flop on the trial code to the DAC
               if (settle_r != 4'(SETTLE)) begin
                  settle_r <= settle_r + 4'h1;
               end else begin
                  settle_r <= 4'h0;
                  if (bitIdx_r == 4'h0) begin
                     sar.result <= keptTrial;
                     sar.done <= 1'b1;
                     sar.busy <= 1'b0;
                     sar.trial <= keptTrial;
                     state_r <= IDLE;
                  end else begin
                     sar.trial <= keptTrial | bitMask(bitIdx_r - 4'h1);
                     bitIdx_r <= bitIdx_r - 4'h1;
                  end
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> vts_control_top.sv
// Control registers for the fixed reference gains and temperature indicator,
// plus converter channel select, start and the 10-bit result pair.
// Assumes a classic Wishbone master on mclk and an analog front end fed by the outputs.
//
// Operation
// - Indicator powered only while sensor enable set
// - Range bit set selects high range
// - Converter gain codes give 4x, 2x, 1x
// - Ready flag always reads one, read-only
// - Dedicated mux channel routes indicator output
// - Ten-bit successive approximation into result pair
//
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module vts_control_top #(
   parameter int ACQ_CYCLES = vts_pkg::ACQ_CYCLES, // Indicator settle count
   parameter int SETTLE = vts_pkg::SETTLE_CYCLES // Cycles per result bit, less one
) (
   input wire logic mclk, // System clock, 40 MHz
   input wire logic rst, // Async reset, high
   input wire logic cyc_i, // Wishbone cycle
   input wire logic stb_i, // Wishbone strobe
   input wire logic we_i, // Wishbone write
   input wire logic [3:0] adr_i, // Wishbone byte address
   input wire logic [3:0] sel_i, // Wishbone byte enables
   input wire logic [31:0] dat_i, // Wishbone write data
   output logic [31:0] dat_o, // Wishbone read data
   output logic ack_o, // Wishbone acknowledge
   input wire logic compRaw, // Converter comparator pin
   output logic referenceEnable, // Fixed reference on
   output logic tempSensorEnable, // Indicator power
   output logic tempRangeHigh, // Indicator high range
   output logic [2:0] compRefLevel, // Comparator level {4x,2x,1x}
   output logic [2:0] convRefLevel, // Converter level {4x,2x,1x}
   output logic [3:0] muxChannel, // Converter input channel
   output logic tempChannelSelected, // Indicator routed to converter
   output logic [9:0] sarTrial // Trial code to converter DAC
);

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   vts_sar_if sar ();

   logic [7:0] control_r;
   logic [3:0] channel_r;
   logic [9:0] result_r;
   logic [31:0] acqCount_r;
   logic startReq_r;
   logic busAccess;
   logic wrStrobe;
   logic [7:0] rdByte;
   logic acqSettled;

   // Gain code to one-hot level; code zero leaves the consumer unpowered
   function automatic logic [2:0] gainLevel(input logic [1:0] code);
      logic [2:0] lvl;
      lvl = vts_pkg::LEVEL_OFF;
      unique case (code)
         vts_pkg::GAIN_CODE_4X: lvl = vts_pkg::LEVEL_4X;
         vts_pkg::GAIN_CODE_2X: lvl = vts_pkg::LEVEL_2X;
         vts_pkg::GAIN_CODE_1X: lvl = vts_pkg::LEVEL_1X;
         vts_pkg::GAIN_CODE_OFF: lvl = vts_pkg::LEVEL_OFF;
      endcase
      gainLevel = lvl;
   endfunction

   // -------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------
   // Write commits on the edge where the master sees ack, not one earlier
   assign busAccess = cyc_i & stb_i;
   assign wrStrobe = busAccess & we_i & ack_o & sel_i[0];
   assign acqSettled = (acqCount_r == 32'h0000_0000);

   // Read mux; reserved bits and unmapped offsets read as zero
   always_comb begin
      rdByte = 8'h00;
      unique case (adr_i)
         vts_pkg::OFF_VREF_TEMP_CONTROL: begin
            rdByte = control_r;
            rdByte[vts_pkg::POS_REFERENCE_READY] = 1'b1;
         end
         vts_pkg::OFF_CONV_CONTROL: begin
            rdByte[vts_pkg::POS_CHANNEL_LO +: 4] = channel_r;
            rdByte[vts_pkg::POS_ACQ_SETTLED] = acqSettled;
            // Done counts as busy: the result pair and settle timer load one edge later
            rdByte[vts_pkg::POS_CONV_GO] = sar.busy | startReq_r | sar.done;
         end
         vts_pkg::OFF_RESULT_HIGH: rdByte = {6'h00, result_r[9:8]};
         vts_pkg::OFF_RESULT_LOW: rdByte = result_r[7:0];
         default: rdByte = 8'h00;
      endcase
   end

   // -------------------------------------------------------------------
   // Wishbone handshake
   // -------------------------------------------------------------------
   // One wait state: ack one cycle after the request, dropped the next
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= busAccess & ~ack_o;
         if (busAccess & ~ack_o & ~we_i) begin
            dat_o <= {24'h00_0000, rdByte};
         end
      end
   end

   // -------------------------------------------------------------------
   // Reference and indicator control register
   // -------------------------------------------------------------------
   // Ready bit is not stored, so a write can never clear it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         control_r <= vts_pkg::RST_VREF_TEMP_CONTROL;
      end else if (wrStrobe && adr_i == vts_pkg::OFF_VREF_TEMP_CONTROL) begin
         control_r <= dat_i[7:0];
         control_r[vts_pkg::POS_REFERENCE_READY] <= 1'b0;
      end
   end

   // Analog controls straight from flops to avoid decode glitches
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         referenceEnable <= 1'b0;
         tempSensorEnable <= 1'b0;
         tempRangeHigh <= 1'b0;
         compRefLevel <= vts_pkg::LEVEL_OFF;
         convRefLevel <= vts_pkg::LEVEL_OFF;
      end else begin
         referenceEnable <= control_r[vts_pkg::POS_REFERENCE_ENABLE];
         tempSensorEnable <= control_r[vts_pkg::POS_TEMP_SENSOR_ENABLE];
         tempRangeHigh <= control_r[vts_pkg::POS_TEMP_RANGE_SELECT];
         compRefLevel <= gainLevel(control_r[vts_pkg::POS_COMP_GAIN_LO +: 2]);
         convRefLevel <= gainLevel(control_r[vts_pkg::POS_CONV_GAIN_LO +: 2]);
      end
   end

   // -------------------------------------------------------------------
   // Channel select and conversion start
   // -------------------------------------------------------------------
   // A start written while busy is dropped rather than queued
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         channel_r <= vts_pkg::RST_CHANNEL;
         startReq_r <= 1'b0;
      end else begin
         startReq_r <= 1'b0;
         if (wrStrobe && adr_i == vts_pkg::OFF_CONV_CONTROL) begin
            channel_r <= dat_i[vts_pkg::POS_CHANNEL_LO +: 4];
            startReq_r <= dat_i[vts_pkg::POS_CONV_GO] & ~sar.busy;
         end
      end
   end

   // Start pulse to the engine, one cycle wide
   assign sar.start = startReq_r;

   // Routing outputs; one channel code is wired to the indicator
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         muxChannel <= vts_pkg::RST_CHANNEL;
         tempChannelSelected <= 1'b0;
      end else begin
         muxChannel <= channel_r;
         tempChannelSelected <= (channel_r == vts_pkg::TEMP_CHANNEL);
      end
   end

   // -------------------------------------------------------------------
   // Indicator acquisition timer
   // -------------------------------------------------------------------
   // Advisory only: software still owns the wait, this just reports it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         acqCount_r <= 32'h0000_0000;
      end else if (wrStrobe && adr_i == vts_pkg::OFF_CONV_CONTROL &&
                   dat_i[vts_pkg::POS_CHANNEL_LO +: 4] == vts_pkg::TEMP_CHANNEL &&
                   channel_r != vts_pkg::TEMP_CHANNEL) begin
         acqCount_r <= 32'(ACQ_CYCLES);
      end else if (sar.done && channel_r == vts_pkg::TEMP_CHANNEL) begin
         acqCount_r <= 32'(ACQ_CYCLES);
      end else if (!acqSettled) begin
         acqCount_r <= acqCount_r - 32'h0000_0001;
      end
   end

   // -------------------------------------------------------------------
   // Result capture
   // -------------------------------------------------------------------
   // Held until the next conversion ends; no partial results shown
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         result_r <= 10'h000;
      end else if (sar.done) begin
         result_r <= sar.result;
      end
   end

   // Trial code to the DAC from a flop; the engine allows for this delay
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sarTrial <= 10'h000;
      end else begin
         sarTrial <= sar.trial;
      end
   end

   // -------------------------------------------------------------------
   // Converter engine
   // -------------------------------------------------------------------
   vts_sar_engine #(
      .SETTLE(SETTLE)
   ) u_engine (
      .mclk(mclk),
      .rst(rst),
      .compRaw(compRaw),
      .sar(sar.engine)
   );

endmodule
`default_nettype wire

// >>> vts_control_assertions.sv
// Checker for the control top: bus handshake, ready flag, field copies, decodes.
// Assumes it is bound to vts_control_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module vts_control_assertions #(
   parameter int ACQ_CYCLES = 20, // Indicator settle count
   parameter int SETTLE = 3 // Cycles per result bit, less one
) (
   input wire logic mclk, // System clock
   input wire logic rst, // Async reset, high
   input wire logic cyc_i, // Bus cycle
   input wire logic stb_i, // Bus strobe
   input wire logic we_i, // Bus write
   input wire logic [3:0] adr_i, // Bus address
   input wire logic [3:0] sel_i, // Byte enables
   input wire logic [31:0] dat_i, // Write data
   input wire logic [31:0] dat_o, // Read data
   input wire logic ack_o, // Acknowledge
   input wire logic tempSensorEnable, // Indicator power
   input wire logic tempRangeHigh, // Indicator range
   input wire logic [2:0] compRefLevel, // Comparator level
   input wire logic [2:0] convRefLevel, // Converter level
   input wire logic [3:0] muxChannel, // Converter channel
   input wire logic tempChannelSelected // Indicator routed
);
   // ----------------------------------------------------------------
   // Sequences and properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // Expected one-hot level; code zero means that output is off
   function automatic logic [2:0] lvl(input logic [1:0] c);
      return (c == 2'h0) ? 3'h0 : (3'h1 << (c - 2'h1));
   endfunction

   sequence sReq;
      cyc_i && stb_i && !ack_o;
   endsequence
   // Write commit edge for the control register, low lane enabled
   sequence sWr0;
      ack_o && cyc_i && stb_i && we_i && adr_i == 4'h0 && sel_i[0];
   endsequence
   sequence sRd;
      ack_o && !we_i;
   endsequence

   a_ack_after_req: assert property (sReq |=> ack_o) else $error("ack missing after request");
   a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   a_ready_reads_one: assert property (sRd |-> (adr_i != 4'h0 || dat_o[6])) else $error("ready bit read zero");
   a_upper_zero: assert property (sRd |-> dat_o[31:8] == 24'h00_0000) else $error("upper read bits set");
   // Copies land two edges after commit: register, then output flop
   a_sensor_follow: assert property (sWr0 |=> ##1 tempSensorEnable == $past(dat_i[5], 2))
      else $error("sensor enable not copied");
   a_range_follow: assert property (sWr0 |=> ##1 tempRangeHigh == $past(dat_i[4], 2))
      else $error("range select not copied");
   a_comp_decode: assert property (sWr0 |=> ##1 compRefLevel == lvl($past(dat_i[3:2], 2)))
      else $error("comparator level wrong");
   a_conv_decode: assert property (sWr0 |=> ##1 convRefLevel == lvl($past(dat_i[1:0], 2)))
      else $error("converter level wrong");
   a_chan_flag: assert property (tempChannelSelected == (muxChannel == 4'h8)) else $error("channel flag wrong");
endmodule

bind vts_control_top vts_control_assertions #(.ACQ_CYCLES(ACQ_CYCLES), .SETTLE(SETTLE)) uChk (
   .mclk(mclk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
   .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tempSensorEnable(tempSensorEnable),
   .tempRangeHigh(tempRangeHigh), .compRefLevel(compRefLevel), .convRefLevel(convRefLevel),
   .muxChannel(muxChannel), .tempChannelSelected(tempChannelSelected));
`default_nettype wire

// >>> vts_control_top_tb_top.sv
// Self-checking bench for the reference and indicator control top.
// Assumes the design and checker files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module vts_control_top_tb_top;
   localparam int ACQ = 20;
   logic mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, compRaw = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'h0, muxChannel;
   logic [31:0] wdat = 32'h0000_0000, rdat, datO;
   logic ackO, referenceEnable, tempSensorEnable, tempRangeHigh, tempChannelSelected;
   logic [2:0] compRefLevel, convRefLevel;
   logic [9:0] sarTrial;
   int badCount = 0, checked = 0;

   // ----------------------------------------------------------------
   // Clock, design, bus and compare tasks
   // ----------------------------------------------------------------
   always #12.5 mclk = ~mclk;

   vts_control_top #(.ACQ_CYCLES(ACQ), .SETTLE(3)) DUT (.mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(datO), .ack_o(ackO), .compRaw(compRaw),
      .referenceEnable(referenceEnable), .tempSensorEnable(tempSensorEnable), .tempRangeHigh(tempRangeHigh),
      .compRefLevel(compRefLevel), .convRefLevel(convRefLevel), .muxChannel(muxChannel),
      .tempChannelSelected(tempChannelSelected), .sarTrial(sarTrial));

   // One classic cycle; held until ack is sampled, bounded wait
   task automatic wbCycle(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do begin
         @(posedge mclk);
         n++;
      end while (ackO !== 1'b1 && n < 40);
      rdat = datO;
      if (n >= 40) badCount++;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic chkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         badCount++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chkPin(input string what, input logic [9:0] exp, input logic [9:0] got);
      checked++;
      if (got !== exp) begin
         badCount++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rdChk(input logic [3:0] a, input logic [31:0] exp, input string what);
      wbCycle(1'b0, a, 32'h0000_0000, 4'h0);
      chkWord(what, exp, rdat);
   endtask

   // Level expected from a gain code: 01 1x, 10 2x, 11 4x, 00 off
   function automatic logic [2:0] lvl(input logic [1:0] c);
      return (c == 2'h0) ? 3'h0 : (3'h1 << (c - 2'h1));
   endfunction

   task automatic printVerdict();
      $display("Comparisons %0d, mismatches %0d", checked, badCount);
      if (badCount == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Watchdog far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge mclk);
      badCount++;
      printVerdict();
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] d;
      logic [1:0] k;
      int n;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chkPin("levels at reset", 10'h000, {4'h0, compRefLevel, convRefLevel});
      rdChk(4'h0, 32'h0000_0040, "control reset");
      // Every gain code on both fields, ready bit written as zero
      for (int c = 0; c < 4; c++) begin
         k = c[1:0];
         d = {k[0] ^ k[1], 1'b0, k[0], k[1], k, ~k};
         wbCycle(1'b1, 4'h0, {24'h00_0000, d}, 4'h1);
         repeat (2) @(posedge mclk);
         chkPin("enables", {7'h00, d[7], k[0], k[1]}, {7'h00, referenceEnable, tempSensorEnable, tempRangeHigh});
         chkPin("comparator level", {7'h00, lvl(k)}, {7'h00, compRefLevel});
         chkPin("converter level", {7'h00, lvl(~k)}, {7'h00, convRefLevel});
         rdChk(4'h0, {24'h00_0000, d | 8'h40}, "control readback");
      end
      // Low lane disabled and unmapped writes must change nothing
      wbCycle(1'b1, 4'h0, 32'h0000_00FF, 4'hE);
      rdChk(4'h0, 32'h0000_007C, "lane ignored");
      wbCycle(1'b1, 4'h1, 32'h0000_00FF, 4'hF);
      rdChk(4'h1, 32'h0000_0000, "unmapped read");
      rdChk(4'h0, 32'h0000_007C, "after unmapped write");
      // Route the indicator and watch the settle flag
      wbCycle(1'b1, 4'h4, 32'h0000_0080, 4'h1);
      rdChk(4'h4, 32'h0000_0080, "settle pending");
      chkPin("channel pins", {5'h00, 1'b1, 4'h8}, {5'h00, tempChannelSelected, muxChannel});
      repeat (ACQ) @(posedge mclk);
      rdChk(4'h4, 32'h0000_0084, "settled");
      // Comparator held high gives all ones, held low all zeros
      for (int v = 1; v >= 0; v--) begin
         compRaw <= v[0];
         wbCycle(1'b1, 4'h4, 32'h0000_0081, 4'h1);
         n = 0;
         do begin
            wbCycle(1'b0, 4'h4, 32'h0000_0000, 4'h0);
            n++;
         end while (rdat[0] !== 1'b0 && n < 30);
         chkWord("conversion end", 32'h0000_0080, rdat);
         rdChk(4'h8, v ? 32'h0000_0003 : 32'h0000_0000, "result high");
         rdChk(4'hC, v ? 32'h0000_00FF : 32'h0000_0000, "result low");
         chkPin("trial code", v ? 10'h3FF : 10'h000, sarTrial);
         repeat (ACQ) @(posedge mclk);
      end
      wbCycle(1'b1, 4'h4, 32'h0000_0000, 4'h1);
      repeat (2) @(posedge mclk);
      chkPin("channel released", 10'h000, {5'h00, tempChannelSelected, muxChannel});
      printVerdict();
   end
endmodule
`default_nettype wire
